// ==== logic/irq_guard_pkg.sv ====
// constants for the interrupt mask bank and field-on guard timer
// assumes a 100 MHz system clock and a 13.56 MHz carrier reference
package irq_guard_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FIELD_GUARD = 8'h15;
    localparam logic [7:0] IDX_MASK_MAIN = 8'h16;
    localparam logic [7:0] IDX_MASK_TIMER = 8'h17;
    localparam logic [7:0] IDX_MASK_ERROR = 8'h18;
    localparam logic [7:0] IDX_MASK_TARGET = 8'h19;
    localparam logic [7:0] IDX_STAT_MAIN = 8'h1A;
    localparam logic [7:0] IDX_STAT_TARGET = 8'h1D;

    // ------------------------------------------------------------
    // reset values and implemented bits per group
    // ------------------------------------------------------------
    localparam logic [7:0] FIELD_GUARD_RST = 8'h33;
    localparam logic [7:0] MASK_RST = 8'h00;
    // group order: 0 main, 1 timer/field, 2 error/wake-up, 3 target
    localparam logic [3:0][7:0] GROUP_VALID = {8'h7B, 8'hFF, 8'hFF, 8'hFE};

    // ------------------------------------------------------------
    // bit positions used by local event sources
    // ------------------------------------------------------------
    localparam int BIT_FIFO_LEVEL = 6;
    localparam int BIT_GUARD_EXPIRED = 1;

    // ------------------------------------------------------------
    // fifo water level thresholds in bytes
    // ------------------------------------------------------------
    localparam logic [9:0] RX_LEVEL_BYTES = 10'd300;
    localparam logic [9:0] TX_LEVEL_BYTES = 10'd200;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 100_000_000;
    localparam longint CARRIER_HZ = 13_560_000;
    localparam longint INIT_DELAY_US = 75;
    localparam longint GUARD_STEP_PERIODS = 2048;
    // least times, rounded up to whole clock cycles
    localparam int INIT_DELAY_CYC = int'((INIT_DELAY_US * CLK_HZ + 999_999) / 1_000_000);
    localparam int GUARD_STEP_CYC = int'((GUARD_STEP_PERIODS * CLK_HZ + CARRIER_HZ - 1) / CARRIER_HZ);

    // guard sequencer states, gray along idle-init-guard
    typedef enum logic [1:0]
    {
        G_IDLE = 2'b00,
        G_INIT = 2'b01,
        G_GUARD = 2'b11
    } guard_st_t;

endpackage : irq_guard_pkg

// ==== logic/irq_mask_and_field_guard.sv ====
// interrupt status and mask bank with field-on guard delay timer
// assumes classic wishbone master and event sources on clk_i
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module irq_mask_and_field_guard #(
    parameter int INIT_CYC = irq_guard_pkg::INIT_DELAY_CYC,
    parameter int STEP_CYC = irq_guard_pkg::GUARD_STEP_CYC,
    parameter int CNT_W = 16
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // event pulses per group
    input wire logic [7:0] main_evt_i,
    input wire logic [7:0] timer_evt_i,
    input wire logic [7:0] error_evt_i,
    input wire logic [7:0] target_evt_i,
    // fifo fill state
    input wire logic [9:0] fifo_count_i,
    input wire logic rx_active_i,
    input wire logic tx_active_i,
    // field-on sequencing
    input wire logic field_on_start_i,
    output logic field_guard_busy_o,
    output logic field_guard_done_o,
    // interrupt
    output logic irq_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (INIT_CYC < 1 || INIT_CYC > 2 ** CNT_W || STEP_CYC < 1 || STEP_CYC > 2 ** CNT_W)
    begin : g_bad_param
        $error("guard counts do not fit the counter width");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0][7:0] stat_r, stat_nxt;
    logic [3:0][7:0] mask_r, mask_nxt;
    logic [3:0][7:0] evt;
    logic [7:0] field_guard_value_r, field_guard_value_nxt;
    logic fifo_level_flag_r, fifo_level_flag_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic irq_r, irq_nxt;
    irq_guard_pkg::guard_st_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [7:0] units_r, units_nxt;
    logic done_r, done_nxt;
    logic busy_r, busy_nxt;
    logic req;
    logic [7:0] idx;
    logic [1:0] grp;
    logic is_mask;
    logic is_stat;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // one access per request; ack low in the cycle after it is given
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign idx = {2'b00, wb_adr_i[7:2]};
    assign is_mask = idx >= irq_guard_pkg::IDX_MASK_MAIN && idx <= irq_guard_pkg::IDX_MASK_TARGET;
    assign is_stat = idx >= irq_guard_pkg::IDX_STAT_MAIN && idx <= irq_guard_pkg::IDX_STAT_TARGET;
    assign grp = is_mask ? 2'(idx - irq_guard_pkg::IDX_MASK_MAIN) : 2'(idx - irq_guard_pkg::IDX_STAT_MAIN);

    // ------------------------------------------------------------
    // fifo water level
    // ------------------------------------------------------------
    // level thresholds
    always_comb
    begin
        fifo_level_flag_nxt = (rx_active_i && fifo_count_i > irq_guard_pkg::RX_LEVEL_BYTES)
                           || (tx_active_i && fifo_count_i < irq_guard_pkg::TX_LEVEL_BYTES);
    end

    // ------------------------------------------------------------
    // event collection
    // ------------------------------------------------------------
    // local sources join the external pulses; level flags on rising edge only
    always_comb
    begin
        evt = {target_evt_i, error_evt_i, timer_evt_i, main_evt_i};
        evt[0][irq_guard_pkg::BIT_FIFO_LEVEL] = main_evt_i[irq_guard_pkg::BIT_FIFO_LEVEL]
                                              || (fifo_level_flag_nxt && !fifo_level_flag_r);
        // guard expiry is reported as an event
        evt[1][irq_guard_pkg::BIT_GUARD_EXPIRED] = timer_evt_i[irq_guard_pkg::BIT_GUARD_EXPIRED]
                                                 || done_nxt;
    end

    // ------------------------------------------------------------
    // register file next values
    // ------------------------------------------------------------
    // reserved bits are forced to zero so they read back as zero
    always_comb
    begin
        mask_nxt = mask_r;
        field_guard_value_nxt = field_guard_value_r;
        rdat_nxt = 32'h0000_0000;
        ack_nxt = req;
        for (int g = 0; g < 4; g++)
        begin
            stat_nxt[g] = stat_r[g];
        end
        if (req && wb_we_i && wb_sel_i[0])
        begin
            if (idx == irq_guard_pkg::IDX_FIELD_GUARD)
            begin
                field_guard_value_nxt = wb_dat_i[7:0];
            end
            if (is_mask)
            begin
                mask_nxt[grp] = wb_dat_i[7:0] & irq_guard_pkg::GROUP_VALID[grp];
            end
            // writing a one also clears a status flag
            if (is_stat)
            begin
                stat_nxt[grp] = stat_r[grp] & ~wb_dat_i[7:0];
            end
        end
        if (req && !wb_we_i)
        begin
            if (idx == irq_guard_pkg::IDX_FIELD_GUARD)
            begin
                rdat_nxt = {24'h00_0000, field_guard_value_r};
            end
            if (is_mask)
            begin
                rdat_nxt = {24'h00_0000, mask_r[grp]};
            end
            // read returns flags then clears them
            if (is_stat)
            begin
                rdat_nxt = {24'h00_0000, stat_r[grp]};
                stat_nxt[grp] = 8'h00;
            end
        end
        // new events win over any clear in the same cycle
        for (int g = 0; g < 4; g++)
        begin
            stat_nxt[g] = stat_nxt[g] | (evt[g] & irq_guard_pkg::GROUP_VALID[g]);
        end
        irq_nxt = |(stat_nxt & ~mask_nxt);
    end

    // ------------------------------------------------------------
    // register file flops
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // masks clear, guard takes its default
            mask_r <= {4{irq_guard_pkg::MASK_RST}};
            field_guard_value_r <= irq_guard_pkg::FIELD_GUARD_RST;
            stat_r <= '0;
            fifo_level_flag_r <= 1'b0;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end
        else if (ce_i)
        begin
            mask_r <= mask_nxt;
            field_guard_value_r <= field_guard_value_nxt;
            stat_r <= stat_nxt;
            fifo_level_flag_r <= fifo_level_flag_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // field-on guard sequencer
    // ------------------------------------------------------------
    // the guard value is sampled at start, so a rewrite mid-run has no effect
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        units_nxt = units_r;
        done_nxt = 1'b0;
        case (st_r)
            irq_guard_pkg::G_IDLE:
            begin
                if (field_on_start_i)
                begin
                    st_nxt = irq_guard_pkg::G_INIT;
                    cnt_nxt = CNT_W'(INIT_CYC - 1);
                    units_nxt = field_guard_value_r;
                end
            end
            irq_guard_pkg::G_INIT:
            begin
                if (cnt_r == '0)
                begin
                    if (units_r == 8'h00)
                    begin
                        done_nxt = 1'b1;
                        st_nxt = irq_guard_pkg::G_IDLE;
                    end
                    else
                    begin
                        st_nxt = irq_guard_pkg::G_GUARD;
                        cnt_nxt = CNT_W'(STEP_CYC - 1);
                    end
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            irq_guard_pkg::G_GUARD:
            begin
                if (cnt_r == '0)
                begin
                    if (units_r == 8'h01)
                    begin
                        done_nxt = 1'b1;
                        st_nxt = irq_guard_pkg::G_IDLE;
                    end
                    else
                    begin
                        units_nxt = units_r - 8'h01;
                        cnt_nxt = CNT_W'(STEP_CYC - 1);
                    end
                end
                else
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default:
            begin
                st_nxt = irq_guard_pkg::G_IDLE;
            end
        endcase
        busy_nxt = st_nxt != irq_guard_pkg::G_IDLE;
    end

    // sequencer flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r <= irq_guard_pkg::G_IDLE;
            cnt_r <= '0;
            units_r <= 8'h00;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            units_r <= units_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_dat_o = rdat_r;
    assign wb_ack_o = ack_r;
    assign irq_o = irq_r;
    assign field_guard_busy_o = busy_r;
    assign field_guard_done_o = done_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_irq_tracks_flags: assert property (irq_o == |(stat_r & ~mask_r))
        else $error("irq does not match unmasked flags");

    a_reset_values: assert property ($past(rst_i) |-> mask_r == '0 && field_guard_value_r == 8'h33)
        else $error("bad values after reset");

    a_reserved_zero: assert property (!mask_r[0][0] && !mask_r[3][7] && !mask_r[3][2])
        else $error("reserved mask bit set");

    // read clears when no new event
    a_read_clears: assert property (req && !wb_we_i && is_stat && ce_i && evt[grp] == 8'h00
        |=> stat_r[$past(grp)] == 8'h00 && ack_r)
        else $error("status not cleared by read");

    a_level_sets_flag: assert property (ce_i && fifo_level_flag_nxt && !fifo_level_flag_r
        |=> stat_r[0][6])
        else $error("fifo level flag not set");

    // fixed wait leads into guard steps
    a_init_to_guard: assert property (st_r == irq_guard_pkg::G_INIT && cnt_r == '0 && units_r != 8'h00
        && ce_i |=> st_r == irq_guard_pkg::G_GUARD && cnt_r == CNT_W'(STEP_CYC - 1))
        else $error("init wait did not enter guard");

    // unit counts down once per step
    a_guard_step: assert property (st_r == irq_guard_pkg::G_GUARD && cnt_r == '0 && units_r > 8'h01
        && ce_i |=> units_r == $past(units_r) - 8'h01)
        else $error("guard unit not consumed");

    // start loads value and init wait count and raises busy
    a_start_loads: assert property (st_r == irq_guard_pkg::G_IDLE && field_on_start_i && ce_i
        |=> busy_r && units_r == $past(field_guard_value_r) && cnt_r == CNT_W'(INIT_CYC - 1))
        else $error("guard start not loaded");

    // done pulse is one cycle with flag set
    a_done_flagged: assert property (field_guard_done_o && ce_i |-> stat_r[1][1] ##1 !field_guard_done_o)
        else $error("guard done not flagged");

    // bus ack lasts one cycle
    a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held too long");

endmodule : irq_mask_and_field_guard

`default_nettype wire

// ==== testbench/wb_host_model.sv ====
// wishbone host model standing in for the software side of the register bus
// assumes a classic slave on the same clock that acks in its own time
`timescale 1ns/1ps
`default_nettype none

module wb_host_model (
    // clock
    input wire logic clk_i,
    // wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);

    // idle bus from time zero so the slave never sees an unknown strobe
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // one classic cycle: hold everything until ack is sampled high
    // no cycle count is assumed; a lost ack is left to the bench watchdog
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= wr;
        adr_o <= adr;
        sel_o <= 4'hF;
        dat_o <= {24'h0, wd};
        do
        begin
            @(posedge clk_i);
        end
        while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
    endtask : xfer

endmodule : wb_host_model

`default_nettype wire

// ==== testbench/irq_mask_and_field_guard_tb.sv ====
// self-checking bench for the interrupt mask bank and field-on guard timer
// assumes the host model drives the register bus on the same clock
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("ERROR at %0t: value %h expected %h", $time, got, exp); \
        end \
    end

module irq_mask_and_field_guard_tb;

    // short guard counts keep the run brief
    localparam int INIT_C = 4;
    localparam int STEP_C = 3;

    logic clk_i, rst_i, ce_i, wb_cyc, wb_stb, wb_we, wb_ack, rx_active, tx_active, start, busy, done, irq;
    logic [7:0] wb_adr, q, m, bitv;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [9:0] fifo_count;
    logic [7:0] evt [4];
    int num_errors = 0;
    int tests_run = 0;
    int seed = 10918;
    int n, cnt;

    // ------------------------------------------------------------
    // clock, design, host
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    irq_mask_and_field_guard #(.INIT_CYC(INIT_C), .STEP_CYC(STEP_C)) irq_mask_and_field_guard_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .main_evt_i(evt[0]), .timer_evt_i(evt[1]), .error_evt_i(evt[2]), .target_evt_i(evt[3]),
        .fifo_count_i(fifo_count), .rx_active_i(rx_active), .tx_active_i(tx_active),
        .field_on_start_i(start), .field_guard_busy_o(busy), .field_guard_done_o(done), .irq_o(irq)
    );

    wb_host_model wb_host_model_inst (
        .clk_i(clk_i), .cyc_o(wb_cyc), .stb_o(wb_stb), .we_o(wb_we), .adr_o(wb_adr),
        .sel_o(wb_sel), .dat_o(wb_dat_w), .dat_i(wb_dat_r), .ack_i(wb_ack)
    );

    // ------------------------------------------------------------
    // expectations and helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] adr_of(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction : adr_of

    // edges from the one that takes start to the one that raises done
    function automatic int guard_cycles(input int val);
        return INIT_C + val * STEP_C;
    endfunction : guard_cycles

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        wb_host_model_inst.xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        wb_host_model_inst.xfer(1'b0, a, 8'h00, d);
    endtask : rd

    // rising fill condition must set the level flag, the quiet one must not
    task automatic fifo_case(input logic r, input logic t, input logic [9:0] quiet, input logic [9:0] trip);
        @(posedge clk_i);
        rx_active <= r;
        tx_active <= t;
        fifo_count <= quiet;
        repeat (2) @(posedge clk_i);
        rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN), q);
        `CHK(q, 8'h00)
        @(posedge clk_i);
        fifo_count <= trip;
        repeat (2) @(posedge clk_i);
        #1 `CHK(irq, 1'b1)
        rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN), q);
        `CHK(q, 8'h01 << irq_guard_pkg::BIT_FIFO_LEVEL)
        @(posedge clk_i);
        rx_active <= 1'b0;
        tx_active <= 1'b0;
    endtask : fifo_case

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // watchdog: the whole sequence needs well under ten thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        $display("ERROR at %0t: run did not finish", $time);
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        evt = '{default: 8'h00};
        fifo_count = 10'd0;
        rx_active = 1'b0;
        tx_active = 1'b0;
        start = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, unmapped space reads zero
        #1 `CHK(irq, 1'b0)
        rd(adr_of(irq_guard_pkg::IDX_FIELD_GUARD), q);
        `CHK(q, irq_guard_pkg::FIELD_GUARD_RST)
        for (int g = 0; g < 4; g++)
        begin
            rd(adr_of(irq_guard_pkg::IDX_MASK_MAIN + 8'(g)), q);
            `CHK(q, 8'h00)
        end
        wr(8'h7C, 8'hFF);
        rd(8'h7C, q);
        `CHK(q, 8'h00)
        $display("test reset_values done");
        // every source against a random mask
        for (int g = 0; g < 4; g++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                m = 8'($random(seed));
                bitv = 8'h01 << b;
                wr(adr_of(irq_guard_pkg::IDX_MASK_MAIN + 8'(g)), m);
                rd(adr_of(irq_guard_pkg::IDX_MASK_MAIN + 8'(g)), q);
                `CHK(q, m & irq_guard_pkg::GROUP_VALID[g])
                @(posedge clk_i);
                evt[g] <= bitv;
                @(posedge clk_i);
                evt[g] <= 8'h00;
                #1 `CHK(irq, |(bitv & irq_guard_pkg::GROUP_VALID[g] & ~m))
                rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN + 8'(g)), q);
                `CHK(q, bitv & irq_guard_pkg::GROUP_VALID[g])
                rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN + 8'(g)), q);
                `CHK(q, 8'h00)
                #1 `CHK(irq, 1'b0)
            end
            wr(adr_of(irq_guard_pkg::IDX_MASK_MAIN + 8'(g)), 8'h00);
        end
        $display("test mask_sources done");
        // thresholds on both sides of the boundary
        fifo_case(1'b1, 1'b0, 10'd300, 10'd301);
        fifo_case(1'b0, 1'b1, 10'd200, 10'd199);
        $display("test fifo_level done");
        // guard delay for the advised and random values
        for (int i = 0; i < 4; i++)
        begin
            n = (i == 0) ? 0 : (i == 1) ? 33 : ($random(seed) & 8'hFF);
            wr(adr_of(irq_guard_pkg::IDX_FIELD_GUARD), 8'(n));
            rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN + 8'h01), q);
            @(posedge clk_i);
            start <= 1'b1;
            @(posedge clk_i);
            start <= 1'b0;
            cnt = 0;
            // a second start while busy must not restart the count
            do
            begin
                @(posedge clk_i);
                cnt++;
                start <= (cnt == 2);
                // last run: five frozen edges must stretch the count by five
                ce_i <= !(i == 3 && cnt < 6);
                #1;
                if (cnt == 1) `CHK(busy, 1'b1)
            end
            while (done !== 1'b1 && cnt < 1000);
            `CHK(cnt, guard_cycles(n) + ((i == 3) ? 5 : 0))
            `CHK(busy, 1'b0)
            @(posedge clk_i);
            start <= 1'b0;
            #1 `CHK(irq, 1'b1)
            rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN + 8'h01), q);
            `CHK(q, 8'h01 << irq_guard_pkg::BIT_GUARD_EXPIRED)
        end
        $display("test field_guard done");
        // reset in mid-run restores masks, guard value and flags
        wr(adr_of(irq_guard_pkg::IDX_MASK_TIMER), 8'hA5);
        @(posedge clk_i);
        evt[2] <= 8'h81;
        @(posedge clk_i);
        evt[2] <= 8'h00;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 `CHK(irq, 1'b0)
        rd(adr_of(irq_guard_pkg::IDX_MASK_TIMER), q);
        `CHK(q, irq_guard_pkg::MASK_RST)
        rd(adr_of(irq_guard_pkg::IDX_STAT_MAIN + 8'h02), q);
        `CHK(q, 8'h00)
        rd(adr_of(irq_guard_pkg::IDX_FIELD_GUARD), q);
        `CHK(q, irq_guard_pkg::FIELD_GUARD_RST)
        $display("test mid_reset done");
        complete_run();
    end

endmodule : irq_mask_and_field_guard_tb

`default_nettype wire
